// File: core_peripheral_speed_select_bench.sv
/*
  core_peripheral_speed_select_bench: self-checking bench for cps_speed_select.
  assumes: apb word index addressing, oscHalfPhase toggled by the bench.
*/
`timescale 1ns/100ps

module core_peripheral_speed_select_bench;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, er;
  logic        securityDoubleSpeed, oscHalfPhase, oscRun, coreDoubleSpeed;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0]  pstrb, cpuPeriods;
  logic [1:0]  uartMode;
  logic [7:0]  periphFast, rd;
  int          errorCnt, comparisons, cycles;
  localparam logic [7:0] C = cps_pkg::CLOCK_SPEED_CONTROL_IDX;
  localparam logic [7:0] S = cps_pkg::SPI_CLOCK_SPEED_CONTROL_IDX;

  cps_speed_select u_cps_speed_select (.clk, .srst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .pready, .prdata, .pslverr, .securityDoubleSpeed, .oscHalfPhase,
    .uartMode, .coreDoubleSpeed, .cpuPeriods, .periphFast);

  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  // osc/2 phase stops when oscRun is low, so no rising edge reaches the core bit
  always @(posedge clk) begin
    if (oscRun) oscHalfPhase <= ~oscHalfPhase;
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errorCnt++;
      $display("Error at %0t: timeout", $time);
      give_verdict();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errorCnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     input logic [3:0] st);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    pstrb   <= st;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    // request stands until pready is seen high at a rising edge
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) begin
      errorCnt++;
      $display("Error at %0t: no pready", $time);
    end
    rd      = prdata[7:0];
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic settle;
    repeat (6) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errorCnt, comparisons);
    if (errorCnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb, uartMode} = '0;
    {srst, securityDoubleSpeed, oscHalfPhase, oscRun, errorCnt, comparisons, cycles} = 0;
    srst = 1; securityDoubleSpeed = 1; oscRun = 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    test_strap();
    test_standard();
    test_double();
    test_uart();
    test_spi();
    test_switch();
    test_rereset();
    give_verdict();
  end

  task automatic test_strap;
    apb(0, C, 8'h00, 4'hf);
    chk(rd, 8'h01);
    chk({7'h00, er}, 8'h00);
    apb(0, S, 8'h00, 4'hf);
    chk(rd & 8'h01, 8'h00);
    settle();
    chk({7'h00, coreDoubleSpeed}, 8'h01);
    $display("reset done");
  endtask

  task automatic test_standard;
    apb(1, C, 8'haa, 4'hf);
    apb(0, C, 8'h00, 4'hf);
    chk(rd, 8'haa);
    settle();
    chk({4'h0, cpuPeriods}, 8'h0c);
    chk(periphFast, 8'h00);
    $display("standard done");
  endtask

  task automatic test_double;
    apb(1, C, 8'hab, 4'hf);
    settle();
    chk({4'h0, cpuPeriods}, 8'h06);
    chk(periphFast, 8'haa);
    $display("double done");
  endtask

  task automatic test_uart;
    apb(1, C, 8'hff, 4'hf);
    uartMode <= 2'h1;
    settle();
    chk(periphFast, 8'h88);
    @(posedge clk);
    uartMode <= 2'h2;
    settle();
    chk(periphFast, 8'h80);
    @(posedge clk);
    uartMode <= 2'h0;
    $display("uart done");
  endtask

  task automatic test_spi;
    apb(1, S, 8'h01, 4'hf);
    apb(0, S, 8'h00, 4'hf);
    chk(rd & 8'h01, 8'h01);
    settle();
    chk(periphFast, 8'h00);
    apb(1, S, 8'h00, 4'h0);
    apb(0, S, 8'h00, 4'hf);
    chk(rd & 8'h01, 8'h01);
    apb(0, 8'h8e, 8'h00, 4'hf);
    chk({7'h00, er}, 8'h01);
    $display("spi done");
  endtask

  // hold osc/2 still: the core bit must wait for its rising edge
  task automatic test_switch;
    @(posedge clk);
    oscRun <= 1'b0;
    apb(1, C, 8'h00, 4'hf);
    settle();
    chk({7'h00, coreDoubleSpeed}, 8'h01);
    @(posedge clk);
    oscRun <= 1'b1;
    settle();
    chk({4'h0, cpuPeriods}, 8'h0c);
    chk({7'h00, coreDoubleSpeed}, 8'h00);
    $display("switch done");
  endtask

  // second reset with the security byte clear
  task automatic test_rereset;
    apb(1, C, 8'hfe, 4'hf);
    apb(1, S, 8'h01, 4'hf);
    @(posedge clk);
    securityDoubleSpeed <= 1'b0;
    srst                <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(0, C, 8'h00, 4'hf);
    chk(rd, 8'h00);
    apb(0, S, 8'h00, 4'hf);
    chk(rd & 8'h01, 8'h00);
    settle();
    chk({4'h0, cpuPeriods}, 8'h0c);
    chk({7'h00, coreDoubleSpeed}, 8'h00);
    $display("rereset done");
  endtask
endmodule

// File: cps_pkg.sv
/*
  cps_pkg: register map, field positions, reset values and speed codes for
  the core and peripheral speed select block.
  assumes: 8-bit registers on the low byte of a 32-bit apb data bus.
*/
package cps_pkg;
  // printed offsets are not all multiples of four: they are word indexes
  localparam logic [7:0] CLOCK_SPEED_CONTROL_IDX     = 8'h8f;
  localparam logic [7:0] SPI_CLOCK_SPEED_CONTROL_IDX = 8'haf;
  localparam int         IDX_SHIFT                   = 2;

  localparam int CORE_DOUBLE_SPEED_POS       = 0;
  localparam int TIMER0_SPEED_SEL_POS        = 1;
  localparam int TIMER1_SPEED_SEL_POS        = 2;
  localparam int TIMER2_SPEED_SEL_POS        = 3;
  localparam int UART_SPEED_SEL_POS          = 4;
  localparam int COUNTER_ARRAY_SPEED_SEL_POS = 5;
  localparam int WATCHDOG_SPEED_SEL_POS      = 6;
  localparam int TWO_WIRE_SPEED_SEL_POS      = 7;
  localparam int SPI_SPEED_SEL_POS           = 0;

  localparam int NUM_PERIPH = 8;
  localparam int SPI_IDX    = 7;

  localparam logic [6:0] PERIPH_SEL_RESET = 7'h00;
  localparam logic       SPI_SEL_RESET    = 1'b0;

  localparam logic [3:0] PERIODS_FAST = 4'h6;
  localparam logic [3:0] PERIODS_STD  = 4'hc;

  localparam logic [1:0] UART_MODE_SYNC  = 2'h0;
  localparam logic [1:0] UART_MODE_FIXED = 2'h2;
endpackage

// File: cps_speed_select.sv
/*
  cps_speed_select: two byte-wide clock speed control registers on apb and
  the per-peripheral period selection derived from them.
  assumes: one clock, synchronous reset, security byte level stable at reset
  release, osc/2 phase supplied as a synchronous level.
*/
// Design decision made here: register access over APB.
`timescale 1ns/100ps

// Operation
// (RULE1) control byte: seven peripheral bits, core bit0
// (RULE2) core bit clear 12 periods, set 6
// (RULE3) peripheral bits ignored while core standard
// (RULE4) double speed, clear bit gives 6
// (RULE5) double speed, set bit gives 12
// (RULE6) uart bit only for modes 0, 2
// (RULE7) reset clears bits 7..1, bit0 from security
// (RULE8) second register bit0 selects spi speed
// (RULE9) spi register upper bits reserved, bit0 resets 0
// (RULE10) whole-byte access only, no bit addressing
// (RULE11) core bit change only on osc/2 rise
// (RULE12) writes update in the same bus cycle
module cps_speed_select (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        securityDoubleSpeed,
  input  wire logic        oscHalfPhase,
  input  wire logic [1:0]  uartMode,
  output logic             coreDoubleSpeed,
  output logic [3:0]       cpuPeriods,
  output logic [7:0]       periphFast
);
  localparam logic [11:0] ADDR_CTRL =
    12'(cps_pkg::CLOCK_SPEED_CONTROL_IDX) << cps_pkg::IDX_SHIFT;
  localparam logic [11:0] ADDR_SPI =
    12'(cps_pkg::SPI_CLOCK_SPEED_CONTROL_IDX) << cps_pkg::IDX_SHIFT;

  logic       coreReq_q;
  logic [6:0] periphSel_q;
  logic       spiSel_q;
  logic       coreEff_q;
  logic       halfPhase_q;
  logic       resetSeen_q;
  logic       setup;
  logic       wrCtrl;
  logic       wrSpi;
  logic       hitAny;
  logic [7:0] selAll;
  wire  logic [7:0] fastD;

  assign setup  = psel && !penable;
  assign hitAny = (paddr == ADDR_CTRL) || (paddr == ADDR_SPI);
  // byte lane 0 must be written: partial bit writes do not exist
  assign wrCtrl = setup && pwrite && pstrb[0] && (paddr == ADDR_CTRL); // see (RULE10)
  assign wrSpi  = setup && pwrite && pstrb[0] && (paddr == ADDR_SPI);  // see (RULE10)

  // zero wait states: the answer is raised in the setup cycle's edge
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= setup;
      pslverr <= setup && !hitAny;
      prdata  <= 32'h0000_0000;
      if (setup && !pwrite && paddr == ADDR_CTRL) begin
        prdata <= {24'h000000, periphSel_q, coreReq_q}; // see (RULE1)
      end else if (setup && !pwrite && paddr == ADDR_SPI) begin
        // reserved bits are undefined; zero is a legal choice
        prdata <= {24'h000000, 7'h00, spiSel_q}; // see (RULE9)
      end
    end
  end

  // strap taken one edge after reset release, never inside the reset term
  always_ff @(posedge clk) begin
    if (srst) begin
      resetSeen_q <= 1'b1;
    end else begin
      resetSeen_q <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      coreReq_q   <= 1'b0;
      periphSel_q <= cps_pkg::PERIPH_SEL_RESET; // see (RULE7)
      spiSel_q    <= cps_pkg::SPI_SEL_RESET;    // see (RULE9)
    end else begin
      if (resetSeen_q) begin
        coreReq_q <= securityDoubleSpeed; // see (RULE7)
      end else if (wrCtrl) begin
        coreReq_q <= pwdata[cps_pkg::CORE_DOUBLE_SPEED_POS]; // see (RULE12)
      end
      if (wrCtrl) begin
        periphSel_q <= pwdata[7:1]; // see (RULE12)
      end
      if (wrSpi) begin
        spiSel_q <= pwdata[cps_pkg::SPI_SPEED_SEL_POS]; // see (RULE8)
      end
    end
  end

  // effective core speed moves only on the osc/2 rising edge to avoid glitches
  always_ff @(posedge clk) begin
    if (srst) begin
      halfPhase_q <= 1'b0;
      coreEff_q   <= 1'b0;
    end else begin
      halfPhase_q <= oscHalfPhase;
      if (oscHalfPhase && !halfPhase_q) begin
        coreEff_q <= coreReq_q; // see (RULE11)
      end
    end
  end

  assign selAll = {spiSel_q, periphSel_q[6:0]};

  genvar g;
  generate
    for (g = 0; g < cps_pkg::NUM_PERIPH; g++) begin : gPeriph
      if (g == cps_pkg::UART_SPEED_SEL_POS - 1) begin : gUart
        // outside modes 0 and 2 the uart keeps the core rate
        assign fastD[g] = coreEff_q &&
          ((uartMode == cps_pkg::UART_MODE_SYNC || uartMode == cps_pkg::UART_MODE_FIXED)
            ? !selAll[g] : 1'b1); // see (RULE6)

        uart_std_a: assert property (@(posedge clk) disable iff (srst) // see (RULE3)
          !coreEff_q |=> !periphFast[g])
          else $error("uart fast while core standard");

        uart_sel_a: assert property (@(posedge clk) disable iff (srst) // see (RULE6)
          coreEff_q && !uartMode[0] |=> periphFast[g] == !$past(selAll[g]))
          else $error("uart speed bit ignored in modes 0 and 2");
      end else begin : gPlain
        assign fastD[g] = coreEff_q && !selAll[g]; // see (RULE3) see (RULE4) see (RULE5)

        plain_std_a: assert property (@(posedge clk) disable iff (srst) // see (RULE3)
          !coreEff_q |=> !periphFast[g])
          else $error("peripheral fast while core standard");

        plain_fast_a: assert property (@(posedge clk) disable iff (srst) // see (RULE4)
          coreEff_q && !selAll[g] |=> periphFast[g])
          else $error("cleared speed bit not fast");

        plain_slow_a: assert property (@(posedge clk) disable iff (srst) // see (RULE5)
          selAll[g] |=> !periphFast[g])
          else $error("set speed bit not standard");
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (srst) begin
      coreDoubleSpeed <= 1'b0;
      cpuPeriods      <= cps_pkg::PERIODS_STD;
      periphFast      <= 8'h00;
    end else begin
      coreDoubleSpeed <= coreEff_q;
      cpuPeriods      <= coreEff_q ? cps_pkg::PERIODS_FAST : cps_pkg::PERIODS_STD; // see (RULE2)
      periphFast      <= fastD;
    end
  end

  // core speed switching
  ctrl_stable_a: assert property (@(posedge clk) disable iff (srst) // see (RULE11)
    !(oscHalfPhase && !halfPhase_q) |=> $stable(coreEff_q))
    else $error("core speed changed off osc/2 rise");

  eff_follow_a: assert property (@(posedge clk) disable iff (srst) // see (RULE11)
    oscHalfPhase && !halfPhase_q |=> coreEff_q == $past(coreReq_q))
    else $error("core speed not taken on osc/2 rise");

  // speed outputs
  std_ignore_a: assert property (@(posedge clk) disable iff (srst) // see (RULE3)
    !coreEff_q |=> periphFast == 8'h00)
    else $error("peripheral fast while core standard");

  cpu_period_a: assert property (@(posedge clk) disable iff (srst) // see (RULE2)
    1'b1 |=> cpuPeriods == ($past(coreEff_q) ? cps_pkg::PERIODS_FAST : cps_pkg::PERIODS_STD))
    else $error("cpu period mismatch");

  core_out_a: assert property (@(posedge clk) disable iff (srst) // see (RULE2)
    1'b1 |=> coreDoubleSpeed == $past(coreEff_q))
    else $error("core speed output lags");

  cpu_fast_out_a: assert property (@(posedge clk) disable iff (srst) // see (RULE2)
    coreDoubleSpeed |-> cpuPeriods == cps_pkg::PERIODS_FAST)
    else $error("cpu period disagrees with core speed");

  fast_needs_core_a: assert property (@(posedge clk) disable iff (srst) // see (RULE3)
    periphFast != 8'h00 |-> coreDoubleSpeed)
    else $error("peripheral fast without core double speed");

  timer0_fast_a: assert property (@(posedge clk) disable iff (srst) // see (RULE4)
    coreEff_q && !periphSel_q[0] |=> periphFast[0])
    else $error("timer0 not fast");

  timer0_std_a: assert property (@(posedge clk) disable iff (srst) // see (RULE5)
    periphSel_q[0] |=> !periphFast[0])
    else $error("timer0 not standard");

  spi_sel_a: assert property (@(posedge clk) disable iff (srst) // see (RULE8)
    coreEff_q |=> periphFast[7] == !$past(spiSel_q))
    else $error("spi speed mismatch");

  uart_mode_a: assert property (@(posedge clk) disable iff (srst) // see (RULE6)
    coreEff_q && uartMode[0] |=> periphFast[3])
    else $error("uart bit acted outside modes 0 and 2");

  // stored bits
  write_upd_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    wrCtrl && !resetSeen_q |=> periphSel_q == $past(pwdata[7:1]))
    else $error("control write lost");

  core_write_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    wrCtrl && !resetSeen_q |=> coreReq_q == $past(pwdata[cps_pkg::CORE_DOUBLE_SPEED_POS]))
    else $error("core bit write lost");

  ctrl_hold_a: assert property (@(posedge clk) disable iff (srst) // see (RULE1)
    !wrCtrl |=> $stable(periphSel_q))
    else $error("peripheral bits changed without a write");

  strap_load_a: assert property (@(posedge clk) disable iff (srst) // see (RULE7)
    resetSeen_q |=> coreReq_q == $past(securityDoubleSpeed))
    else $error("core bit not loaded from security byte");

  strap_once_a: assert property (@(posedge clk) disable iff (srst) // see (RULE7)
    !resetSeen_q && !wrCtrl |=> $stable(coreReq_q))
    else $error("core bit changed without a write");

  spi_write_a: assert property (@(posedge clk) disable iff (srst) // see (RULE8)
    wrSpi |=> spiSel_q == $past(pwdata[cps_pkg::SPI_SPEED_SEL_POS]))
    else $error("spi bit write lost");

  spi_hold_a: assert property (@(posedge clk) disable iff (srst) // see (RULE8)
    !wrSpi |=> $stable(spiSel_q))
    else $error("spi bit changed without a write");

  strobe_block_a: assert property (@(posedge clk) disable iff (srst) // see (RULE10)
    setup && pwrite && !pstrb[0] |=> $stable(periphSel_q) && $stable(spiSel_q))
    else $error("write without byte lane 0 took effect");

  reset_val_a: assert property (@(posedge clk) // see (RULE7) see (RULE9)
    srst |=> periphSel_q == 7'h00 && !spiSel_q)
    else $error("reset values wrong");

  // register bus answers
  bus_ready_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    setup |=> pready ##1 !pready)
    else $error("apb answer timing");

  ready_only_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    !setup |=> !pready)
    else $error("pready without a setup cycle");

  ready_pulse_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    pready |=> !pready)
    else $error("pready held too long");

  read_core_a: assert property (@(posedge clk) disable iff (srst) // see (RULE1)
    setup && !pwrite && paddr == ADDR_CTRL |=> prdata[0] == $past(coreReq_q))
    else $error("core bit read wrong");

  read_sel_a: assert property (@(posedge clk) disable iff (srst) // see (RULE1)
    setup && !pwrite && paddr == ADDR_CTRL |=> prdata[7:1] == $past(periphSel_q))
    else $error("peripheral bits read wrong");

  read_spi_a: assert property (@(posedge clk) disable iff (srst) // see (RULE8)
    setup && !pwrite && paddr == ADDR_SPI |=> prdata[0] == $past(spiSel_q))
    else $error("spi bit read wrong");

  spi_reserved_a: assert property (@(posedge clk) disable iff (srst) // see (RULE9)
    setup && !pwrite && paddr == ADDR_SPI |=> prdata[7:1] == 7'h00)
    else $error("reserved spi bits not zero");

  upper_zero_a: assert property (@(posedge clk) disable iff (srst) // see (RULE9)
    1'b1 |=> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  idle_data_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    !(setup && !pwrite) |=> prdata == 32'h0000_0000)
    else $error("read data outside a read answer");

  unmapped_err_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    setup && !hitAny |=> pslverr)
    else $error("unmapped access without error");

  mapped_ok_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    !(setup && !hitAny) |=> !pslverr)
    else $error("error on a mapped access");

  // error only ever rides on an answer
  err_ready_a: assert property (@(posedge clk) disable iff (srst) // see (RULE12)
    pslverr |-> pready)
    else $error("pslverr without pready");
endmodule
